//--- src/urb_pkg.sv
// register map, field positions and reset values of the receive buffer block
package urb_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam int              ADDR_W        = 12;
	localparam logic [11:0]     OFF_STATUS_A  = 12'h000;
	localparam logic [11:0]     OFF_CONTROL_B = 12'h004;
	localparam logic [11:0]     OFF_CONTROL_C = 12'h008;
	localparam logic [11:0]     OFF_DATA      = 12'h00C;

	// ****************************************************************
	// serial_status_reg_a fields
	// ****************************************************************
	localparam int              STA_RXC       = 7;
	localparam int              STA_FE        = 4;
	localparam int              STA_DOR       = 3;
	localparam int              STA_UPE       = 2;

	// ****************************************************************
	// serial_control_reg_b fields
	// ****************************************************************
	localparam int              CTB_RXCIE     = 7;
	localparam int              CTB_RXEN      = 4;
	localparam int              CTB_CSZ2      = 2;
	localparam int              CTB_RXB8      = 1;
	localparam int              CTB_TXB8      = 0;
	localparam logic [7:0]      CTB_WMASK     = 8'h95;
	localparam logic [7:0]      CTB_RST       = 8'h00;

	// ****************************************************************
	// serial_control_reg_c fields
	// ****************************************************************
	localparam int              CTC_PMH       = 5;
	localparam int              CTC_PML       = 4;
	localparam int              CTC_SBS       = 3;
	localparam int              CTC_CSZ1      = 2;
	localparam int              CTC_CSZ0      = 1;
	localparam logic [7:0]      CTC_WMASK     = 8'h3E;
	localparam logic [7:0]      CTC_RST       = 8'h06;

	// ****************************************************************
	// character size codes
	// ****************************************************************
	localparam logic [2:0]      CSZ_5BIT      = 3'h0;
	localparam logic [2:0]      CSZ_6BIT      = 3'h1;
	localparam logic [2:0]      CSZ_7BIT      = 3'h2;
	localparam logic [2:0]      CSZ_8BIT      = 3'h3;
	localparam logic [2:0]      CSZ_9BIT      = 3'h7;

	localparam int              RX_DEPTH      = 2;

endpackage

//--- src/urb_rx_buffer.sv
// receive buffer, error flags and apb register slave of the serial receiver
`timescale 1ns/100ps

// What the document requires of this block and of the software that drives it
// RULE1 - short characters read with zero upper bits
// RULE2 - software reads ninth bit before data
// RULE3 - software reads status before data
// RULE4 - data read pops fifo, flags follow
// RULE5 - receive complete set while buffer nonempty
// RULE6 - receiver disable flushes whole buffer
// RULE7 - interrupt requested while flag and enables set
// RULE8 - handler must read data to stop interrupt
// RULE9 - writes to error flags are ignored
// RULE10 - software writes zeros to error flags
// RULE11 - error flags raise no interrupt
// RULE12 - frame error shows first stop bit
// RULE13 - frame error ignores stop bit count
// RULE14 - overrun when full, held, new start
// RULE15 - overrun marks lost frames, clears on store
// RULE16 - parity check on high bit, low selects
// RULE17 - parity result stored with each entry
// RULE18 - parity error only if checked, failed
// RULE19 - parity error zero when checking off
// RULE20 - disabling receiver is immediate, aborts reception
// RULE21 - software flushes by reading until empty
// RULE22 - enabling receiver takes over receive pin
// RULE23 - completed frame moves into receive buffer
// RULE24 - data read when empty changes nothing
module urb_rx_buffer #(
	parameter int DEPTH = urb_pkg::RX_DEPTH
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rstn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [urb_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        global_irq_enable,
	output logic                             rx_irq,
	input  wire logic                        serial_rx_pin,
	output logic                             rx_serial_in,
	output logic                             rx_pin_override,
	output logic                             rx_abort,
	output logic      [2:0]                  char_size_select,
	output logic                             stop_bit_count_select,
	input  wire logic                        frame_start,
	input  wire logic                        frame_done,
	input  wire logic [8:0]                  frame_bits,
	input  wire logic                        frame_parity,
	input  wire logic                        frame_stop
);
	import urb_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0]    ctb_r;
	logic [7:0]    ctc_r;
	logic [8:0]    fifo_data [DEPTH];
	logic          fifo_fe   [DEPTH];
	logic          fifo_pe   [DEPTH];
	logic          fifo_dor  [DEPTH];
	logic [PW-1:0] rd_ptr_r;
	logic [PW-1:0] wr_ptr_r;
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic          hold_valid_r;
	logic [8:0]    hold_data_r;
	logic          hold_fe_r;
	logic          hold_pe_r;
	logic          dor_pend_r;
	logic [31:0]   prdata_r;
	logic          cap_valid_r;

	logic          rxen;
	logic          rxcie;
	logic          pmh;
	logic          pml;
	logic          rxc;
	logic          push;
	logic          pop;
	logic          setup;
	logic          access;
	logic          mapped;
	logic          wr_ctb;
	logic          wr_ctc;
	logic          rd_data_acc;
	logic          overrun;
	logic [8:0]    csz_mask;
	logic [8:0]    frame_masked;
	logic          parity_bad;
	logic [8:0]    head_data;
	logic          head_fe;
	logic          head_pe;
	logic          head_dor;
	logic [31:0]   rd_word;

	assign rxen   = ctb_r[CTB_RXEN];
	assign rxcie  = ctb_r[CTB_RXCIE];
	assign pmh    = ctc_r[CTC_PMH];
	assign pml    = ctc_r[CTC_PML];
	assign char_size_select      = {ctb_r[CTB_CSZ2], ctc_r[CTC_CSZ1], ctc_r[CTC_CSZ0]};
	assign stop_bit_count_select = ctc_r[CTC_SBS];

	// ****************************************************************
	// pin ownership
	// ****************************************************************
	assign rx_pin_override = rxen;                          // [RULE22]
	assign rx_serial_in    = rxen & serial_rx_pin;          // [RULE22]
	// the shift logic drops a half-received frame at once on disable
	assign rx_abort        = ~rxen;                         // [RULE20]

	// ****************************************************************
	// apb decode
	// ****************************************************************
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == OFF_STATUS_A) | (paddr == OFF_CONTROL_B) |
	                (paddr == OFF_CONTROL_C) | (paddr == OFF_DATA);
	assign pready  = access;
	assign pslverr = access & ~mapped;
	assign prdata  = prdata_r;
	assign wr_ctb  = access & pwrite & pstrb[0] & (paddr == OFF_CONTROL_B);
	assign wr_ctc  = access & pwrite & pstrb[0] & (paddr == OFF_CONTROL_C);
	assign rd_data_acc = access & ~pwrite & (paddr == OFF_DATA);

	// ****************************************************************
	// character mask and parity
	// ****************************************************************
	always_comb begin
		case (char_size_select)
			CSZ_5BIT: csz_mask = 9'h01F;
			CSZ_6BIT: csz_mask = 9'h03F;
			CSZ_7BIT: csz_mask = 9'h07F;
			CSZ_8BIT: csz_mask = 9'h0FF;
			CSZ_9BIT: csz_mask = 9'h1FF;
			default:  csz_mask = 9'h0FF;
		endcase
	end

	// masking at store time keeps unused upper bits zero on every read
	assign frame_masked = frame_bits & csz_mask;             // [RULE1]
	// pml low selects even parity, high selects odd
	assign parity_bad   = ((^frame_masked) ^ frame_parity) != pml; // [RULE16] [RULE17]

	// ****************************************************************
	// shift register holding stage
	// ****************************************************************
	assign push    = hold_valid_r & (count_r != CNT_FULL);   // [RULE23]
	assign pop     = rd_data_acc & cap_valid_r & (count_r != '0); // [RULE4] [RULE24]
	assign overrun = rxen & frame_start & hold_valid_r & (count_r == CNT_FULL); // [RULE14]

	always_ff @(posedge ref_clk) begin
		if (!rstn || !rxen) begin
			hold_valid_r <= 1'b0;                            // [RULE6] [RULE20]
			hold_data_r  <= 9'h000;
			hold_fe_r    <= 1'b0;
			hold_pe_r    <= 1'b0;
		end else if (frame_done) begin
			// a frame done while still held overwrites the older held frame
			hold_valid_r <= 1'b1;
			hold_data_r  <= frame_masked;
			hold_fe_r    <= ~frame_stop;                     // [RULE12] [RULE13]
			hold_pe_r    <= pmh & parity_bad;                // [RULE18] [RULE19]
		end else if (push) begin
			hold_valid_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || !rxen) begin
			dor_pend_r <= 1'b0;
		end else if (overrun) begin
			dor_pend_r <= 1'b1;                              // [RULE14]
		end else if (push) begin
			dor_pend_r <= 1'b0;                              // [RULE15]
		end
	end

	// ****************************************************************
	// receive fifo
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (push) begin
			fifo_data[wr_ptr_r] <= hold_data_r;              // [RULE17]
			fifo_fe[wr_ptr_r]   <= hold_fe_r;
			fifo_pe[wr_ptr_r]   <= hold_pe_r;
			fifo_dor[wr_ptr_r]  <= dor_pend_r;               // [RULE15]
		end
	end

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + CW'(1);
		end else if (pop && !push) begin
			count_nxt = count_r - CW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || !rxen) begin
			rd_ptr_r <= '0;                                  // [RULE6]
			wr_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1); // [RULE4]
			end
			count_r <= count_nxt;
		end
	end

	// flags of an empty buffer read as zero, so stale entries never show
	assign rxc       = rxen & (count_r != '0);               // [RULE5] [RULE20]
	assign head_data = rxc ? fifo_data[rd_ptr_r] : 9'h000;
	assign head_fe   = rxc & fifo_fe[rd_ptr_r];              // [RULE12]
	assign head_pe   = rxc & fifo_pe[rd_ptr_r];              // [RULE18]
	assign head_dor  = rxc & fifo_dor[rd_ptr_r];             // [RULE15]

	// only the receive-complete flag reaches the request; error flags never do
	assign rx_irq = rxc & rxcie & global_irq_enable;         // [RULE7] [RULE11]

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctb_r <= CTB_RST;
		end else if (wr_ctb) begin
			ctb_r <= pwdata[7:0] & CTB_WMASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctc_r <= CTC_RST;
		end else if (wr_ctc) begin
			ctc_r <= pwdata[7:0] & CTC_WMASK;
		end
	end

	// ****************************************************************
	// read data, captured in the setup cycle
	// ****************************************************************
	// status writes have no target: the error flags only change by reception, data reads and receiver disable
	always_comb begin
		rd_word = 32'h0000_0000;                             // [RULE9]
		case (paddr)
			OFF_STATUS_A: begin
				rd_word[STA_RXC] = rxc;
				rd_word[STA_FE]  = head_fe;
				rd_word[STA_DOR] = head_dor;
				rd_word[STA_UPE] = head_pe;
			end
			OFF_CONTROL_B: begin
				rd_word[7:0]      = ctb_r;
				rd_word[CTB_RXB8] = head_data[8];
			end
			OFF_CONTROL_C: begin
				rd_word[7:0] = ctc_r;
			end
			OFF_DATA: begin
				rd_word[7:0] = head_data[7:0] & csz_mask[7:0]; // [RULE1]
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// the pop is tied to what was captured, so a push landing between
	// setup and access never consumes a character that was not returned
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			prdata_r    <= 32'h0000_0000;
			cap_valid_r <= 1'b0;
		end else if (setup) begin
			prdata_r    <= pwrite ? 32'h0000_0000 : rd_word;
			cap_valid_r <= rxc;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_pop_advances: assert property ( // [RULE4]
		(pop && !push) |=> (count_r == $past(count_r) - CW'(1)))
		else $error("data read did not advance the fifo");

	a_rxc_from_push: assert property ( // [RULE5]
		$rose(rxc) |-> $past(push))
		else $error("receive complete rose without a stored frame");

	a_disable_flush: assert property ( // [RULE6]
		!rxen |=> (count_r == '0) && !hold_valid_r && !rxc)
		else $error("receiver disable did not flush the buffer");

	a_irq_needs_flag: assert property ( // [RULE7]
		rx_irq |-> rxc && rxcie && global_irq_enable)
		else $error("interrupt requested without flag and enables");

	a_flags_no_write: assert property ( // [RULE9]
		(access && pwrite && paddr == OFF_STATUS_A && !pop && rxc)
			|=> $stable({head_fe, head_dor, head_pe}))
		else $error("status write changed an error flag");

	a_dor_detect: assert property ( // [RULE14]
		overrun |=> dor_pend_r)
		else $error("overrun not detected");

	a_dor_clear: assert property ( // [RULE15]
		push |=> !dor_pend_r)
		else $error("overrun flag not cleared on store");

	a_parity_off: assert property ( // [RULE19]
		(rxen && frame_done && !pmh) |=> !hold_pe_r)
		else $error("parity error stored with checking off");

	a_empty_read: assert property ( // [RULE24]
		(rd_data_acc && count_r == '0 && !push) |=> (count_r == '0) && $stable(rd_ptr_r))
		else $error("empty read moved the fifo");

	a_short_mask: assert property ( // [RULE1]
		(rd_data_acc && char_size_select == CSZ_5BIT) |-> (prdata[7:5] == 3'h0))
		else $error("upper bits of a short character not zero");

	c_fill_buffer: cover property (push && count_r == CNT_FULL - CW'(1));
	c_overrun:     cover property (overrun);
	c_flush:       cover property (rxc ##1 !rxen);
	c_read_pop:    cover property (pop ##1 rxc);

endmodule

//--- tb/urb_frame_src.sv
// frame link model of the remote transmitter and the receive shift logic
`timescale 1ns/100ps
module urb_frame_src (
	input  wire logic       ref_clk,
	output logic            frame_start,
	output logic            frame_done,
	output logic [8:0]      frame_bits,
	output logic            frame_parity,
	output logic            frame_stop
);
	initial begin
		frame_start  = 1'b0;
		frame_done   = 1'b0;
		frame_bits   = 9'h000;
		frame_parity = 1'b0;
		frame_stop   = 1'b1;
	end

	// ****************************************************************
	// link tasks, entered right after a rising edge
	// ****************************************************************
	task automatic start_bit();
		frame_start <= 1'b1;
		@(posedge ref_clk);
		frame_start <= 1'b0;
		@(posedge ref_clk);
	endtask

	// qualifiers are scrambled once the pulse is gone, so stale values never pass
	task automatic frame(input logic [8:0] bits, input logic par, input logic stop);
		frame_done   <= 1'b1;
		frame_bits   <= bits;
		frame_parity <= par;
		frame_stop   <= stop;
		@(posedge ref_clk);
		frame_done   <= 1'b0;
		frame_bits   <= ~bits;
		frame_parity <= ~par;
		frame_stop   <= ~stop;
		repeat (2) @(posedge ref_clk);
	endtask
endmodule

//--- tb/urb_rx_buffer_tb.sv
// self-checking bench for the receive buffer: apb access and frame hand-over
`timescale 1ns/100ps
module urb_rx_buffer_tb;
	import urb_pkg::*;

	// ****************************************************************
	// signals and instances
	// ****************************************************************
	localparam logic [31:0] RXC = 32'h00000001 << STA_RXC;
	localparam logic [31:0] FE  = 32'h00000001 << STA_FE;
	localparam logic [31:0] DOR = 32'h00000001 << STA_DOR;
	localparam logic [31:0] UPE = 32'h00000001 << STA_UPE;
	logic                ref_clk;
	logic                rstn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata;
	logic [3:0]          pstrb;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                global_irq_enable;
	logic                rx_irq;
	logic                serial_rx_pin;
	logic                rx_serial_in;
	logic                rx_pin_override;
	logic                rx_abort;
	logic [2:0]          char_size_select;
	logic                stop_bit_count_select;
	logic                frame_start;
	logic                frame_done;
	logic [8:0]          frame_bits;
	logic                frame_parity;
	logic                frame_stop;
	logic                last_err;
	int                  bad_count = 0;
	int                  cmp_count = 0;
	logic [31:0]         md_c   [3] = '{32'h00000000, 32'h00000022, 32'h00000004};
	logic [8:0]          md_b   [3] = '{9'h1FE, 9'h003, 9'h0FE};
	logic [31:0]         md_s   [3] = '{RXC, RXC | UPE, RXC};
	logic [31:0]         md_d   [3] = '{32'h0000001E, 32'h00000003, 32'h0000007E};

	urb_rx_buffer i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
		.rx_irq(rx_irq), .serial_rx_pin(serial_rx_pin), .rx_serial_in(rx_serial_in),
		.rx_pin_override(rx_pin_override), .rx_abort(rx_abort),
		.char_size_select(char_size_select), .stop_bit_count_select(stop_bit_count_select),
		.frame_start(frame_start), .frame_done(frame_done), .frame_bits(frame_bits),
		.frame_parity(frame_parity), .frame_stop(frame_stop));
	urb_frame_src i_src (.ref_clk(ref_clk), .frame_start(frame_start),
		.frame_done(frame_done), .frame_bits(frame_bits), .frame_parity(frame_parity),
		.frame_stop(frame_stop));

	// ****************************************************************
	// bus and check tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		apb(1'b0, a, 32'h00000000, q);
		chk(what, exp, q);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****************************************************************
	// clock, watchdog and tests
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end

	initial begin
		logic [31:0] q;
		int n;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		global_irq_enable = 1'b1;
		serial_rx_pin = 1'b1;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		rd(OFF_CONTROL_B, 32'h00000000, "ctrl_b reset");
		rd(OFF_CONTROL_C, 32'h00000006, "ctrl_c reset");
		rd(OFF_STATUS_A, 32'h00000000, "status reset");
		rd(12'h010, 32'h00000000, "unmapped read");
		chk("unmapped error", 32'h00000001, last_err);
		wr(OFF_CONTROL_C, 32'h000000FF);
		rd(OFF_CONTROL_C, 32'h0000003E, "ctrl_c mask");
		chk("stop count select", 32'h00000001, stop_bit_count_select);
		i_src.frame(9'h0A5, 1'b1, 1'b1);
		rd(OFF_STATUS_A, 32'h00000000, "frame while off");
		wr(OFF_CONTROL_B, 32'h00000090);
		chk("pin owned", 32'h00000001, rx_pin_override);
		chk("no abort", 32'h00000000, rx_abort);
		serial_rx_pin <= 1'b0;
		@(posedge ref_clk);
		chk("pin follows", 32'h00000000, rx_serial_in);
		serial_rx_pin <= 1'b1;
		@(posedge ref_clk);
		chk("pin follows", 32'h00000001, rx_serial_in);
		// odd parity, two stop bits: good frame then broken one
		i_src.frame(9'h0A5, 1'b1, 1'b1);
		i_src.frame(9'h0A5, 1'b0, 1'b0);
		chk("irq pending", 32'h00000001, rx_irq);
		rd(OFF_STATUS_A, RXC, "status good");
		rd(OFF_DATA, 32'h000000A5, "data good");
		rd(OFF_STATUS_A, RXC | FE | UPE, "status bad");
		wr(OFF_STATUS_A, 32'h00000000);
		wr(OFF_CONTROL_B, 32'h00000010);
		rd(OFF_STATUS_A, RXC | FE | UPE, "flags kept");
		chk("no error irq", 32'h00000000, rx_irq);
		rd(OFF_DATA, 32'h000000A5, "data bad");
		for (int i = 0; i < 3; i++) begin
			wr(OFF_CONTROL_C, md_c[i]);
			i_src.frame(md_b[i], 1'b1, 1'b1);
			rd(OFF_STATUS_A, md_s[i], "status by mode");
			rd(OFF_DATA, md_d[i], "data by size");
		end
		wr(OFF_CONTROL_C, 32'h00000006);
		wr(OFF_CONTROL_B, 32'h00000094);
		chk("size code", 32'h00000007, char_size_select);
		i_src.frame(9'h1C3, 1'b0, 1'b1);
		chk("irq enabled", 32'h00000001, rx_irq);
		global_irq_enable <= 1'b0;
		@(posedge ref_clk);
		chk("irq gated", 32'h00000000, rx_irq);
		global_irq_enable <= 1'b1;
		rd(OFF_CONTROL_B, 32'h00000096, "ninth bit");
		chk("irq kept", 32'h00000001, rx_irq);
		rd(OFF_DATA, 32'h000000C3, "ninth data");
		chk("irq cleared", 32'h00000000, rx_irq);
		// two buffered, one held, then a new start bit
		wr(OFF_CONTROL_B, 32'h00000010);
		for (int i = 0; i < 3; i++) begin
			i_src.frame(9'(9'h010 + i), 1'b0, 1'b1);
		end
		i_src.start_bit();
		for (int i = 0; i < 3; i++) begin
			rd(OFF_STATUS_A, (i == 2) ? (RXC | DOR) : RXC, "status overrun");
			rd(OFF_DATA, 32'(32'h00000010 + i), "data overrun");
		end
		apb(1'b0, OFF_DATA, 32'h00000000, q);
		rd(OFF_STATUS_A, 32'h00000000, "empty status");
		i_src.frame(9'h055, 1'b0, 1'b1);
		rd(OFF_STATUS_A, RXC, "overrun cleared");
		rd(OFF_DATA, 32'h00000055, "data after empty read");
		i_src.frame(9'h011, 1'b0, 1'b1);
		i_src.frame(9'h012, 1'b0, 1'b1);
		wr(OFF_CONTROL_B, 32'h00000000);
		chk("abort", 32'h00000001, rx_abort);
		chk("pin released", 32'h00000000, rx_serial_in);
		chk("pin not owned", 32'h00000000, rx_pin_override);
		rd(OFF_STATUS_A, 32'h00000000, "flushed while off");
		wr(OFF_CONTROL_B, 32'h00000010);
		rd(OFF_STATUS_A, 32'h00000000, "flushed");
		i_src.frame(9'h033, 1'b0, 1'b1);
		i_src.frame(9'h044, 1'b0, 1'b1);
		n = 0;
		apb(1'b0, OFF_STATUS_A, 32'h00000000, q);
		while (q[STA_RXC] === 1'b1 && n < 4) begin
			apb(1'b0, OFF_DATA, 32'h00000000, q);
			n++;
			apb(1'b0, OFF_STATUS_A, 32'h00000000, q);
		end
		chk("drain reads", 32'h00000002, 32'(n));
		tally_and_finish();
	end
endmodule
